/* File: rtl/iopim_regs.svh */
// constants of the i/o process image mapper: byte counts, limits, widths
// assumes inclusion by the package and by every mapper design file
// ----------------------------------------------------------------------
// Overview of operation
// - pack module bytes by ascending slot from zero
// - diagnostic bytes lead the input image
// - each image is at least two bytes
// - odd image length gets one padding byte
// - five or more link masters raise error
// - allocation follows module type and diagnostic setting
// - interface unit, mode zero: 0 in, 4 out
// - interface unit, mode one: 4 diagnostic in
// - digital inputs: one byte per eight inputs
// - two-channel analogue: four bytes per direction
// - link master takes 44 in, 44 out
// ----------------------------------------------------------------------
`ifndef IOPIM_REGS_SVH
`define IOPIM_REGS_SVH

`define IOPIM_TYPE_W      4
`define IOPIM_LEN_W       11
`define IOPIM_SZ_W        8
`define IOPIM_MAX_SLOTS   32
`define IOPIM_MIN_LEN     11'h002
`define IOPIM_IOL_LIMIT   6'h05
`define IOPIM_DIAG_BYTES  8'h04
`define IOPIM_SI_OUT      8'h04
`define IOPIM_ANA_BYTES   8'h04
`define IOPIM_IOL_BYTES   8'h2C
`define IOPIM_DIG8_BYTES  8'h01
`define IOPIM_DIG16_BYTES 8'h02

`endif

/* File: rtl/iopim_pkg.sv */
// types shared by the process image mapper files
// assumes the constants header sits beside it in rtl/
`include "iopim_regs.svh"

package iopim_pkg;

  // module type codes as reported by each slot
  typedef enum logic [`IOPIM_TYPE_W-1:0] {
    IOPIM_NONE  = 4'h0,
    IOPIM_SI    = 4'h1,
    IOPIM_DI8   = 4'h2,
    IOPIM_DI8OC = 4'h3,
    IOPIM_DI16  = 4'h4,
    IOPIM_DO8   = 4'h5,
    IOPIM_DO16  = 4'h6,
    IOPIM_DIO8  = 4'h7,
    IOPIM_AI2   = 4'h8,
    IOPIM_AO2   = 4'h9,
    IOPIM_AIO2  = 4'hA,
    IOPIM_IOLA  = 4'hB,
    IOPIM_IOLB  = 4'hC
  } iopim_mod_t;

  typedef enum logic [2:0] {
    IOPIM_ST_IDLE = 3'b001,
    IOPIM_ST_WALK = 3'b010,
    IOPIM_ST_DONE = 3'b100
  } iopim_state_t;

  // what a queried image byte belongs to
  typedef enum logic [1:0] {
    IOPIM_K_MOD  = 2'h0,
    IOPIM_K_DIAG = 2'h1,
    IOPIM_K_PAD  = 2'h2,
    IOPIM_K_NONE = 2'h3
  } iopim_kind_t;

endpackage

/* File: rtl/iopim_alloc.sv */
// byte allocation of one module from its type and the diagnostic setting
// assumes a combinational consumer; unknown codes allocate nothing
`timescale 1ns/1ns
`include "iopim_regs.svh"

module iopim_alloc (
  input  iopim_pkg::iopim_mod_t      modType,
  input  wire logic                  diagOn,
  output logic [`IOPIM_SZ_W-1:0]     inBytes,
  output logic [`IOPIM_SZ_W-1:0]     outBytes,
  output logic                       isIol
);
  import iopim_pkg::*;

  // ----------------------------------------------------------------
  // allocation table
  // ----------------------------------------------------------------
  always_comb begin
    inBytes  = '0;
    outBytes = '0;
    isIol    = 1'b0;
    case (modType)
      IOPIM_SI: begin
        inBytes  = diagOn ? `IOPIM_DIAG_BYTES : 8'h00;
        outBytes = `IOPIM_SI_OUT;
      end
      IOPIM_DI8, IOPIM_DI8OC: inBytes = `IOPIM_DIG8_BYTES;
      IOPIM_DI16: inBytes = `IOPIM_DIG16_BYTES;
      IOPIM_DO8: outBytes = `IOPIM_DIG8_BYTES;
      IOPIM_DO16: outBytes = `IOPIM_DIG16_BYTES;
      IOPIM_DIO8: begin
        inBytes  = `IOPIM_DIG8_BYTES;
        outBytes = `IOPIM_DIG8_BYTES;
      end
      IOPIM_AI2: inBytes = `IOPIM_ANA_BYTES;
      IOPIM_AO2: outBytes = `IOPIM_ANA_BYTES;
      IOPIM_AIO2: begin
        inBytes  = `IOPIM_ANA_BYTES;
        outBytes = `IOPIM_ANA_BYTES;
      end
      IOPIM_IOLA, IOPIM_IOLB: begin
        inBytes  = `IOPIM_IOL_BYTES;
        outBytes = `IOPIM_IOL_BYTES;
        isIol    = 1'b1;
      end
      default: begin
        inBytes  = '0;
        outBytes = '0;
        isIol    = 1'b0;
      end
    endcase
  end

endmodule

/* File: rtl/iopim_mapper.sv */
// process image mapper: walks the slots, builds offsets and image lengths,
// answers byte-ownership queries and grants image exchanges
// assumes slot types and diagnostic mode come from logic on clk_sys
`timescale 1ns/1ns
`include "iopim_regs.svh"

module iopim_mapper #(
  parameter int NSLOT = 10
) (
  input  wire logic                          clk_sys,
  input  wire logic                          srst,
  input  wire logic [NSLOT*`IOPIM_TYPE_W-1:0] slotTypes,
  input  wire logic                          diagMode,
  input  wire logic                          xchgReq,
  input  wire logic                          qReq,
  input  wire logic                          qDirOut,
  input  wire logic [`IOPIM_LEN_W-1:0]       qByte,
  output logic                               mapBusy,
  output logic                               mapValid,
  output logic                               mapDone,
  output logic                               xchgAck,
  output logic [`IOPIM_LEN_W-1:0]            inLen,
  output logic [`IOPIM_LEN_W-1:0]            outLen,
  output logic [1:0]                         inPadCnt,
  output logic [1:0]                         outPadCnt,
  output logic                               iolOverErr,
  output logic [NSLOT*`IOPIM_LEN_W-1:0]      slotInOff,
  output logic [NSLOT*`IOPIM_LEN_W-1:0]      slotOutOff,
  output logic                               qAck,
  output iopim_pkg::iopim_kind_t             qKind,
  output logic [4:0]                         qSlot,
  output logic [`IOPIM_SZ_W-1:0]             qLocal
);
  import iopim_pkg::*;

  localparam int LW = `IOPIM_LEN_W;
  localparam int TW = `IOPIM_TYPE_W;
  localparam int ZW = `IOPIM_SZ_W;
  localparam int SW = 5;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // 32 slots of 44 bytes plus diagnostics still fit the 11-bit length
  generate
    if (NSLOT < 1 || NSLOT > `IOPIM_MAX_SLOTS) begin : g_bad
      $error("iopim_mapper: NSLOT out of range 1..32");
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  iopim_state_t             state_r;
  logic [SW-1:0]            idx_r;
  logic [LW-1:0]            inAcc_r;
  logic [LW-1:0]            outAcc_r;
  logic [5:0]               iolCnt_r;
  logic [NSLOT*TW-1:0]      cfgTypes_r;
  logic                     cfgDiag_r;
  logic                     valid_r;
  logic [LW-1:0]            inOff_r  [NSLOT];
  logic [LW-1:0]            outOff_r [NSLOT];
  logic [ZW-1:0]            inSz_r   [NSLOT];
  logic [ZW-1:0]            outSz_r  [NSLOT];
  logic                     isSi_r   [NSLOT];

  logic                     cfgChange;
  logic                     lastSlot;
  iopim_mod_t               curType;
  logic [ZW-1:0]            curIn;
  logic [ZW-1:0]            curOut;
  logic                     curIol;
  logic [LW-1:0]            inFinal;
  logic [LW-1:0]            outFinal;

  // any difference from the snapshot invalidates the map
  assign cfgChange = (slotTypes != cfgTypes_r) || (diagMode != cfgDiag_r);
  assign lastSlot  = (idx_r == SW'(NSLOT - 1));
  assign curType   = iopim_mod_t'(cfgTypes_r[idx_r*TW +: TW]);

  iopim_alloc u_alloc (
    .modType  (curType),
    .diagOn   (cfgDiag_r),
    .inBytes  (curIn),
    .outBytes (curOut),
    .isIol    (curIol)
  );

  // ----------------------------------------------------------------
  // padding
  // ----------------------------------------------------------------
  function automatic logic [LW-1:0] padLen(input logic [LW-1:0] n);
    logic [LW-1:0] r;
    r = n;
    if (n < `IOPIM_MIN_LEN) begin
      r = `IOPIM_MIN_LEN;
    end else if (n[0]) begin
      r = n + LW'(1);
    end
    return r;
  endfunction

  assign inFinal  = padLen(inAcc_r);
  assign outFinal = padLen(outAcc_r);

  // ----------------------------------------------------------------
  // walk sequencer
  // ----------------------------------------------------------------
  // a change seen mid-walk restarts from slot zero so a stale map
  // never becomes valid
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r    <= IOPIM_ST_IDLE;
      idx_r      <= '0;
      cfgTypes_r <= '0;
      cfgDiag_r  <= 1'b0;
      valid_r    <= 1'b0;
    end else begin
      unique case (state_r)
        IOPIM_ST_IDLE: begin
          if (cfgChange || !valid_r) begin
            state_r    <= IOPIM_ST_WALK;
            idx_r      <= '0;
            cfgTypes_r <= slotTypes;
            cfgDiag_r  <= diagMode;
            valid_r    <= 1'b0;
          end
        end
        IOPIM_ST_WALK: begin
          if (cfgChange) begin
            idx_r      <= '0;
            cfgTypes_r <= slotTypes;
            cfgDiag_r  <= diagMode;
          end else if (lastSlot) begin
            state_r <= IOPIM_ST_DONE;
          end else begin
            idx_r <= idx_r + SW'(1);
          end
        end
        IOPIM_ST_DONE: begin
          state_r <= IOPIM_ST_IDLE;
          valid_r <= !cfgChange;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // accumulators
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      inAcc_r  <= '0;
      outAcc_r <= '0;
      iolCnt_r <= '0;
    end else if (state_r == IOPIM_ST_IDLE ||
                 (state_r == IOPIM_ST_WALK && cfgChange)) begin
      // diagnostics reserve the head of the input image
      inAcc_r  <= diagMode ? LW'(`IOPIM_DIAG_BYTES) : '0;
      outAcc_r <= '0;
      iolCnt_r <= '0;
    end else if (state_r == IOPIM_ST_WALK) begin
      if (curType != IOPIM_SI) begin
        inAcc_r <= inAcc_r + LW'(curIn);
      end
      outAcc_r <= outAcc_r + LW'(curOut);
      if (curIol && iolCnt_r != 6'h3F) begin
        iolCnt_r <= iolCnt_r + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-slot offsets and sizes
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSLOT; g++) begin : g_slot
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          inOff_r[g]  <= '0;
          outOff_r[g] <= '0;
          inSz_r[g]   <= '0;
          outSz_r[g]  <= '0;
          isSi_r[g]   <= 1'b0;
        end else if (state_r == IOPIM_ST_WALK && !cfgChange &&
                     idx_r == SW'(g)) begin
          // the interface unit's diagnostics sit at byte 0
          inOff_r[g]  <= (curType == IOPIM_SI) ? '0 : inAcc_r;
          outOff_r[g] <= outAcc_r;
          inSz_r[g]   <= curIn;
          outSz_r[g]  <= curOut;
          isSi_r[g]   <= (curType == IOPIM_SI);
        end
      end
      assign slotInOff[g*LW +: LW]  = inOff_r[g];
      assign slotOutOff[g*LW +: LW] = outOff_r[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // results
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      inLen      <= `IOPIM_MIN_LEN;
      outLen     <= `IOPIM_MIN_LEN;
      inPadCnt   <= 2'h2;
      outPadCnt  <= 2'h2;
      iolOverErr <= 1'b0;
      mapDone    <= 1'b0;
    end else begin
      mapDone <= 1'b0;
      if (state_r == IOPIM_ST_DONE && !cfgChange) begin
        inLen      <= inFinal;
        outLen     <= outFinal;
        inPadCnt   <= 2'(inFinal - inAcc_r);
        outPadCnt  <= 2'(outFinal - outAcc_r);
        iolOverErr <= (iolCnt_r >= `IOPIM_IOL_LIMIT);
        mapDone    <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mapBusy  <= 1'b1;
      mapValid <= 1'b0;
    end else begin
      mapBusy  <= (state_r != IOPIM_ST_IDLE) || cfgChange || !valid_r;
      mapValid <= valid_r && !cfgChange;
    end
  end

  // ----------------------------------------------------------------
  // image exchange grant
  // ----------------------------------------------------------------
  // withheld while the map is stale, so the scanner never sees old offsets
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      xchgAck <= 1'b0;
    end else begin
      xchgAck <= xchgReq && !xchgAck && valid_r && !cfgChange &&
                 state_r == IOPIM_ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // byte ownership query
  // ----------------------------------------------------------------
  iopim_kind_t    hitKind;
  logic [SW-1:0]  hitSlot;
  logic [ZW-1:0]  hitLocal;
  logic [NSLOT-1:0] hit;

  generate
    for (g = 0; g < NSLOT; g++) begin : g_hit
      logic [LW-1:0] base;
      logic [ZW-1:0] size;
      assign base   = qDirOut ? outOff_r[g] : inOff_r[g];
      assign size   = qDirOut ? outSz_r[g] : inSz_r[g];
      assign hit[g] = (size != '0) && (qByte >= base) &&
                      (qByte < base + LW'(size));
    end
  endgenerate

  // lowest slot wins; sizes never overlap in a valid map
  always_comb begin
    logic [LW-1:0] len;
    len      = qDirOut ? outLen : inLen;
    hitKind  = IOPIM_K_NONE;
    hitSlot  = '0;
    hitLocal = '0;
    if (qByte < len) begin
      hitKind = IOPIM_K_PAD;
    end
    // diagnostic head is reserved even when no slot reports the unit
    if (!qDirOut && cfgDiag_r && qByte < LW'(`IOPIM_DIAG_BYTES)) begin
      hitKind = IOPIM_K_DIAG;
    end
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hitSlot  = SW'(i);
        hitLocal = ZW'(qByte - (qDirOut ? outOff_r[i] : inOff_r[i]));
        hitKind  = (!qDirOut && isSi_r[i]) ? IOPIM_K_DIAG : IOPIM_K_MOD;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      qAck   <= 1'b0;
      qKind  <= IOPIM_K_NONE;
      qSlot  <= '0;
      qLocal <= '0;
    end else begin
      qAck <= qReq;
      if (qReq) begin
        qKind  <= mapValid ? hitKind : IOPIM_K_NONE;
        qSlot  <= hitSlot;
        qLocal <= hitLocal;
      end
    end
  end

endmodule

/* File: bench/iopim_scanner_model.sv */
// scanner side of the mapper: raises exchange requests and counts grants
// assumes a single go pulse from the bench for each wanted exchange
`timescale 1ns/1ns

module iopim_scanner_model (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       go,
  input  wire logic       xchgAck,
  output logic            xchgReq,
  output logic [7:0]      grants
);
  // ----------------------------------------------------------------------
  // request handshake
  // ----------------------------------------------------------------------
  // held until the grant is sampled; dropping early would hide a late grant
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      xchgReq <= 1'b0;
      grants  <= 8'h00;
    end else if (xchgReq && xchgAck) begin
      xchgReq <= 1'b0;
      grants  <= grants + 8'h01;
    end else if (go) begin
      xchgReq <= 1'b1;
    end
  end
endmodule

/* File: bench/iopim_mapper_asserts.sv */
// concurrent checks on the process image mapper ports
// assumes the config inputs stay stable while a walk runs
`timescale 1ns/1ns
`include "iopim_regs.svh"

module iopim_mapper_asserts #(
  parameter int NSLOT = 10
) (
  input wire logic                          clk_sys,
  input wire logic                          srst,
  input wire logic [NSLOT*`IOPIM_TYPE_W-1:0] slotTypes,
  input wire logic                          diagMode,
  input wire logic                          xchgReq,
  input wire logic                          qReq,
  input wire logic                          qDirOut,
  input wire logic [`IOPIM_LEN_W-1:0]       qByte,
  input wire logic                          mapBusy,
  input wire logic                          mapValid,
  input wire logic                          mapDone,
  input wire logic                          xchgAck,
  input wire logic [`IOPIM_LEN_W-1:0]       inLen,
  input wire logic [`IOPIM_LEN_W-1:0]       outLen,
  input wire logic [1:0]                    inPadCnt,
  input wire logic                          iolOverErr,
  input wire logic                          qAck,
  input iopim_pkg::iopim_kind_t             qKind
);
  import iopim_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  int iolCnt;

  always_comb begin
    iolCnt = 0;
    for (int s = 0; s < NSLOT; s++) begin
      if (slotTypes[4*s+:4] inside {4'hB, 4'hC}) begin
        iolCnt = iolCnt + 1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  property p_done_valid;
    mapDone |=> mapValid && !mapBusy;
  endproperty
  a_done_valid: assert property (p_done_valid)
    else $error("map not valid after walk end");
  property p_cfg_stale;
    $changed(diagMode) |=> !mapValid;
  endproperty
  a_cfg_stale: assert property (p_cfg_stale)
    else $error("map still valid after config change");
  property p_xchg_valid;
    xchgAck |-> mapValid && $past(xchgReq);
  endproperty
  a_xchg_valid: assert property (p_xchg_valid)
    else $error("exchange granted on stale map");
  property p_min_len;
    mapValid |-> inLen >= 11'h002 && outLen >= 11'h002;
  endproperty
  a_min_len: assert property (p_min_len)
    else $error("image shorter than two bytes");
  property p_pad_two;
    mapValid && inPadCnt == 2'h2 |-> inLen == 11'h002;
  endproperty
  a_pad_two: assert property (p_pad_two)
    else $error("two pad bytes on a long image");
  property p_even;
    mapValid |-> !inLen[0] && !outLen[0];
  endproperty
  a_even: assert property (p_even)
    else $error("odd image length");
  property p_diag_head;
    mapValid && diagMode && $stable(diagMode) |-> inLen >= 11'h004;
  endproperty
  a_diag_head: assert property (p_diag_head)
    else $error("input image lacks diagnostic bytes");
  property p_iol_err;
    mapDone |-> iolOverErr == (iolCnt >= 5);
  endproperty
  a_iol_err: assert property (p_iol_err)
    else $error("link master error flag wrong");
  property p_q_beyond;
    qReq && mapValid && !qDirOut && qByte >= inLen |=> qKind == IOPIM_K_NONE;
  endproperty
  a_q_beyond: assert property (p_q_beyond)
    else $error("byte past image end claimed");
endmodule

bind iopim_mapper iopim_mapper_asserts #(.NSLOT(NSLOT)) i_iopim_mapper_asserts (
  .clk_sys(clk_sys), .srst(srst), .slotTypes(slotTypes),
  .diagMode(diagMode), .xchgReq(xchgReq), .qReq(qReq), .qDirOut(qDirOut),
  .qByte(qByte), .mapBusy(mapBusy), .mapValid(mapValid), .mapDone(mapDone),
  .xchgAck(xchgAck), .inLen(inLen), .outLen(outLen), .inPadCnt(inPadCnt),
  .iolOverErr(iolOverErr), .qAck(qAck), .qKind(qKind));

/* File: bench/testbench.sv */
// self-checking bench: fixed and random module sets through the mapper
// assumes the scanner model sits on the exchange handshake
`timescale 1ns/1ns

module testbench;
  import iopim_pkg::*;
  localparam int N = 8;
  logic clk_sys = 1'b0, srst = 1'b1, diagMode = 1'b0, go = 1'b0;
  logic qReq = 1'b0, qDirOut = 1'b0, xchgReq, mapBusy, mapValid, mapDone;
  logic xchgAck, iolOverErr, qAck;
  logic [N*4-1:0]  slotTypes = '0, rt;
  logic [10:0]     qByte = '0, inLen, outLen, eInLen, eInMod;
  logic [1:0]      inPadCnt, outPadCnt;
  logic [N*11-1:0] slotInOff, slotOutOff;
  logic [4:0]      qSlot, eQSlot;
  logic [7:0]      qLocal, grants;
  logic [16:0]     seed = 17'h1655C;
  iopim_kind_t     qKind;
  int n_errors = 0, samples_checked = 0;

  always #25 clk_sys = ~clk_sys;

  iopim_mapper #(.NSLOT(N)) i_iopim_mapper (.clk_sys(clk_sys), .srst(srst),
    .slotTypes(slotTypes), .diagMode(diagMode), .xchgReq(xchgReq),
    .qReq(qReq), .qDirOut(qDirOut), .qByte(qByte), .mapBusy(mapBusy),
    .mapValid(mapValid), .mapDone(mapDone), .xchgAck(xchgAck),
    .inLen(inLen), .outLen(outLen), .inPadCnt(inPadCnt),
    .outPadCnt(outPadCnt), .iolOverErr(iolOverErr), .slotInOff(slotInOff),
    .slotOutOff(slotOutOff), .qAck(qAck), .qKind(qKind), .qSlot(qSlot),
    .qLocal(qLocal));
  iopim_scanner_model i_iopim_scanner_model (.clk_sys(clk_sys), .srst(srst),
    .go(go), .xchgAck(xchgAck), .xchgReq(xchgReq), .grants(grants));

  function automatic logic [16:0] lfsr(logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction

  function automatic logic [7:0] nbytes(logic [3:0] t, logic o);
    case (t)
      4'h1:        return o ? 8'h04 : 8'h00;
      4'h2, 4'h3:  return o ? 8'h00 : 8'h01;
      4'h4:        return o ? 8'h00 : 8'h02;
      4'h5:        return o ? 8'h01 : 8'h00;
      4'h6:        return o ? 8'h02 : 8'h00;
      4'h7:        return 8'h01;
      4'h8:        return o ? 8'h00 : 8'h04;
      4'h9:        return o ? 8'h04 : 8'h00;
      4'hA:        return 8'h04;
      4'hB, 4'hC:  return 8'h2C;
      default:     return 8'h00;
    endcase
  endfunction

  task automatic chk(string nm, logic [95:0] seen, logic [95:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic check_map();
    logic [10:0] acc;
    logic [1:0]  pad;
    logic [95:0] off;
    int          nIol;
    logic        found;
    found = 1'b0;
    eQSlot = 5'h00;
    for (int d = 0; d < 2; d++) begin
      acc = (d == 0 && diagMode) ? 11'h004 : 11'h000;
      off = '0;
      nIol = 0;
      for (int s = 0; s < N; s++) begin
        if (d == 0 && !found && ((slotTypes[4*s+:4] == 4'h1 && diagMode) ||
            (acc == 11'h000 && nbytes(slotTypes[4*s+:4], 1'b0) != 8'h00))) begin
          found = 1'b1;
          eQSlot = 5'(s);
        end
        off[11*s+:11] = (d == 0 && slotTypes[4*s+:4] == 4'h1) ? '0 : acc;
        acc = acc + {3'h0, nbytes(slotTypes[4*s+:4], d[0])};
        if (slotTypes[4*s+:4] inside {4'hB, 4'hC}) nIol++;
      end
      pad = (acc < 11'h002) ? 2'(11'h002 - acc) : {1'b0, acc[0]};
      if (d == 0) begin
        eInMod = diagMode ? acc - 11'h004 : acc;
        eInLen = acc + 11'(pad);
      end
      chk("len", d ? outLen : inLen, acc + 11'(pad));
      chk("pad", d ? outPadCnt : inPadCnt, pad);
      chk("offsets", d ? slotOutOff : slotInOff, off);
    end
    chk("iolOverErr", iolOverErr, nIol >= 5);
  endtask

  task automatic apply(logic [N*4-1:0] t, logic d, string tn);
    int k;
    logic [7:0] g0;
    g0 = grants;
    if (t === slotTypes && d === diagMode) d = ~d;
    @(posedge clk_sys);
    #1;
    slotTypes = t;
    diagMode = d;
    go = 1'b1;
    k = 0;
    while (mapDone !== 1'b1 && k < 200) begin
      @(posedge clk_sys);
      #1;
      go = 1'b0;
      k++;
    end
    chk("walkDone", k < 200, 1'b1);
    check_map();
    @(posedge clk_sys);
    #1;
    qReq = 1'b1;
    qByte = '0;
    @(posedge clk_sys);
    #1;
    qByte = eInLen;
    chk("qAck", qAck, 1'b1);
    chk("qKind", qKind, diagMode ? IOPIM_K_DIAG :
        (eInMod == 0 ? IOPIM_K_PAD : IOPIM_K_MOD));
    chk("qSlot", qSlot, eQSlot);
    chk("qLocal", qLocal, 8'h00);
    @(posedge clk_sys);
    #1;
    qReq = 1'b0;
    chk("qKindEnd", qKind, IOPIM_K_NONE);
    k = 0;
    while (grants === g0 && k < 20) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("grant", grants === g0, 1'b0);
    $display("done %s", tn);
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    n_errors++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    apply(32'h0000_0015, 1'b0, "one out one unit");
    apply(32'h0000_0015, 1'b1, "diag head");
    apply(32'h0000_0000, 1'b0, "empty");
    apply(32'h0014_2558, 1'b0, "mixed odd input");
    apply(32'h0001_CB52, 1'b0, "two masters");
    apply(32'h0000_CBCB, 1'b1, "four masters");
    apply(32'h000B_CBCB, 1'b0, "five masters");
    apply(32'hA976_3A97, 1'b1, "remaining types");
    repeat (20) begin
      for (int s = 0; s < N; s++) begin
        seed = lfsr(seed);
        rt[4*s+:4] = 4'(seed % 17'h0000D);
      end
      seed = lfsr(seed);
      apply(rt, seed[0], "random");
    end
    final_report();
  end
endmodule
